// ---- rtl/uart_rx_pkg.sv ----
/*
 * Shared constants and types for the serial receive buffer block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package uart_rx_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] FORMAT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] DATA_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] BAUD_OFS = 8'h10;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int ST_RXC = 7;
    localparam int ST_FE = 4;
    localparam int ST_DOR = 3;
    localparam int ST_PE = 2;
    localparam int CT_IE = 7;
    localparam int CT_REN = 4;
    localparam int CT_RX9 = 1;
    localparam int CT_TX9 = 0;
    localparam int FM_UPM_LO = 4;
    localparam int FM_UPM_HI = 5;
    localparam int FM_USBS = 3;
    localparam int FM_CSZ_LO = 0;
    localparam int FM_CSZ_HI = 2;
    localparam int BAUD_W = 16;

    // ==========================================================
    // Reset values and codes
    // ==========================================================
    localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0043;
    localparam logic [2:0] CSZ_RST = 3'h3;
    localparam logic [2:0] CSZ_9BIT = 3'h7;
    localparam logic [3:0] NBITS_MIN = 4'h5;
    localparam logic [3:0] NBITS_8 = 4'h8;
    localparam logic [3:0] NBITS_9 = 4'h9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One buffered character with its own error flags
    typedef struct packed {
        logic [8:0] data;
        logic fe;
        logic dor;
        logic pe;
    } rx_entry_s;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PARITY = 5'h08,
        RX_STOP = 5'h10
    } rx_state_e;

endpackage : uart_rx_pkg

// ---- rtl/rx_fifo.sv ----
/*
 * Small receive buffer: DEPTH entries of received characters.
 * Assumes push and pop come from one clock domain; flush wins.
 */
`timescale 1ns/1ps
module rx_fifo #(
    parameter int DEPTH = 2
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_flush,
    input wire logic i_push_valid,
    output logic o_push_ready,
    input wire uart_rx_pkg::rx_entry_s i_push_data,
    output logic o_pop_valid,
    input wire logic i_pop_ready,
    output uart_rx_pkg::rx_entry_s o_pop_data,
    output logic o_full
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULLC = CW'(DEPTH);

    typedef struct packed {
        uart_rx_pkg::rx_entry_s [DEPTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } fifo_s;

    fifo_s cur;
    fifo_s next_cur;
    logic do_push;
    logic do_pop;

    // Head reads zero when empty so stale flags never show
    assign o_pop_valid = (cur.cnt != '0);
    assign o_full = (cur.cnt == FULLC);
    assign o_push_ready = !o_full;
    assign o_pop_data = o_pop_valid ? cur.mem[cur.rd] : '0;
    assign do_push = i_push_valid && o_push_ready;
    assign do_pop = i_pop_ready && o_pop_valid;

    // Pointer and count update
    always_comb begin
        next_cur = cur;
        if (do_push) begin
            next_cur.mem[cur.wr] = i_push_data;
            next_cur.wr = (cur.wr == LAST) ? '0 : cur.wr + 1'b1;
        end
        if (do_pop) begin
            next_cur.rd = (cur.rd == LAST) ? '0 : cur.rd + 1'b1;
        end
        next_cur.cnt = cur.cnt + CW'(do_push) - CW'(do_pop);
        if (i_flush) begin
            next_cur.wr = '0;
            next_cur.rd = '0;
            next_cur.cnt = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    a_count_bound: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        cur.cnt <= FULLC) else $error("fifo count above depth");

endmodule : rx_fifo

// ---- rtl/uart_rx_buffer.sv ----
/*
 * Serial receiver with two-entry receive buffer, error flags
 * and AXI4-Lite register access.
 * Assumes the receive pin is already synchronous to i_clk_sys
 * and one AXI master issues one write and one read at a time.
 */
`timescale 1ns/1ps
module uart_rx_buffer #(
    parameter int DEPTH = 2,
    parameter logic [15:0] BAUD_INIT = uart_rx_pkg::BAUD_RST
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_serial_receive_pin,
    output logic o_pin_override,
    output logic o_rx_irq,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);
    localparam int BW = uart_rx_pkg::BAUD_W;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        uart_rx_pkg::rx_state_e st;
        logic [BW-1:0] tick;
        logic [3:0] bit_idx;
        logic [8:0] shift;
        logic par;
        uart_rx_pkg::rx_entry_s hold;
        logic hold_valid;
        logic dor_pend;
        logic irq_en;
        logic ren;
        logic tx9;
        logic [2:0] csz;
        logic [1:0] upm;
        logic usbs;
        logic [BW-1:0] baud;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } core_s;

    core_s cur;
    core_s next_cur;
    logic push;
    logic pop;
    logic full;
    logic rxc;
    logic drop;
    logic [3:0] nbits;
    logic [7:0] status_view;
    logic [7:0] control_view;
    uart_rx_pkg::rx_entry_s push_data;
    uart_rx_pkg::rx_entry_s head;

    // ==========================================================
    // Receive buffer
    // ==========================================================
    // flush on disable
    rx_fifo #(.DEPTH(DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_flush(!cur.ren),
        .i_push_valid(push), .o_push_ready(), .i_push_data(push_data),
        .o_pop_valid(rxc), .i_pop_ready(pop), .o_pop_data(head), .o_full(full)
    );

    // ==========================================================
    // Derived views
    // ==========================================================
    // Reserved size codes fall back to eight bits
    always_comb begin
        if (cur.csz == uart_rx_pkg::CSZ_9BIT) begin
            nbits = uart_rx_pkg::NBITS_9;
        end else if (cur.csz[2]) begin
            nbits = uart_rx_pkg::NBITS_8;
        end else begin
            nbits = uart_rx_pkg::NBITS_MIN + {2'h0, cur.csz[1:0]};
        end
    end

    // flags come from the head entry
    // parity error masked while checking is off
    always_comb begin
        status_view = '0;
        status_view[uart_rx_pkg::ST_RXC] = rxc;
        status_view[uart_rx_pkg::ST_FE] = head.fe;
        status_view[uart_rx_pkg::ST_DOR] = head.dor;
        status_view[uart_rx_pkg::ST_PE] = head.pe && cur.upm[1];
        control_view = '0;
        control_view[uart_rx_pkg::CT_IE] = cur.irq_en;
        control_view[uart_rx_pkg::CT_REN] = cur.ren;
        control_view[uart_rx_pkg::CT_RX9] = head.data[8];
        control_view[uart_rx_pkg::CT_TX9] = cur.tx9;
    end

    // pending frame moves in when room appears
    // overrun mark rides with that frame
    assign push = cur.hold_valid && !full && cur.ren;
    always_comb begin
        push_data = cur.hold;
        push_data.dor = cur.dor_pend;
    end

    // start seen with full buffer and frame waiting
    assign drop = cur.ren && (cur.st == uart_rx_pkg::RX_IDLE) && !i_serial_receive_pin
        && cur.hold_valid && full;

    // a data read pops the head
    assign pop = i_s_axi_arvalid && !cur.rvalid && (i_s_axi_araddr == uart_rx_pkg::DATA_OFS);

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_cur = cur;
        // Frame hand-off and overrun bookkeeping
        if (push) begin
            next_cur.hold_valid = 1'b0;
            next_cur.dor_pend = 1'b0;
        end
        if (drop) begin
            next_cur.hold_valid = 1'b0;
            next_cur.dor_pend = 1'b1;
        end
        // Bit timing is baud+1 cycles per bit, start checked mid-bit
        case (cur.st)
            uart_rx_pkg::RX_IDLE: begin
                if (!i_serial_receive_pin) begin
                    next_cur.st = uart_rx_pkg::RX_START;
                    next_cur.tick = cur.baud >> 1;
                end
            end
            uart_rx_pkg::RX_START: begin
                if (cur.tick != '0) begin
                    next_cur.tick = cur.tick - 1'b1;
                end else if (i_serial_receive_pin) begin
                    next_cur.st = uart_rx_pkg::RX_IDLE; // Glitch, not a start
                end else begin
                    next_cur.st = uart_rx_pkg::RX_DATA;
                    next_cur.tick = cur.baud;
                    next_cur.bit_idx = '0;
                    next_cur.shift = '0;
                    next_cur.par = 1'b0;
                end
            end
            uart_rx_pkg::RX_DATA: begin
                if (cur.tick != '0) begin
                    next_cur.tick = cur.tick - 1'b1;
                end else begin
                    // bits above the size stay zero
                    next_cur.shift[cur.bit_idx] = i_serial_receive_pin;
                    next_cur.par = cur.par ^ i_serial_receive_pin;
                    next_cur.tick = cur.baud;
                    next_cur.bit_idx = cur.bit_idx + 1'b1;
                    if (cur.bit_idx == nbits - 1'b1) begin
                        // parity bit only when checking is on
                        next_cur.st = cur.upm[1] ? uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP;
                    end
                end
            end
            uart_rx_pkg::RX_PARITY: begin
                if (cur.tick != '0) begin
                    next_cur.tick = cur.tick - 1'b1;
                end else begin
                    next_cur.par = cur.par ^ i_serial_receive_pin;
                    next_cur.tick = cur.baud;
                    next_cur.st = uart_rx_pkg::RX_STOP;
                end
            end
            uart_rx_pkg::RX_STOP: begin
                if (cur.tick != '0) begin
                    next_cur.tick = cur.tick - 1'b1;
                end else begin
                    // frame complete at first stop bit
                    next_cur.hold_valid = 1'b1;
                    next_cur.hold.data = cur.shift;
                    // later stop bits are not waited for
                    next_cur.hold.fe = !i_serial_receive_pin;
                    // parity result latched with the enable at arrival
                    next_cur.hold.pe = cur.upm[1] && (cur.par ^ cur.upm[0]);
                    next_cur.hold.dor = 1'b0;
                    next_cur.st = uart_rx_pkg::RX_IDLE;
                end
            end
            default: begin
                next_cur.st = uart_rx_pkg::RX_IDLE;
            end
        endcase
        if (!cur.ren) begin
            next_cur.st = uart_rx_pkg::RX_IDLE;
            next_cur.hold_valid = 1'b0;
            next_cur.dor_pend = 1'b0;
        end

        // Write channel capture, either order
        if (i_s_axi_awvalid && !cur.aw_held) begin
            next_cur.aw_held = 1'b1;
            next_cur.awaddr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && !cur.w_held) begin
            next_cur.w_held = 1'b1;
            next_cur.wdata = i_s_axi_wdata;
            next_cur.wstrb = i_s_axi_wstrb;
        end
        if (cur.bvalid && i_s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end
        // Register write once both halves are held
        if (cur.aw_held && cur.w_held && !cur.bvalid) begin
            next_cur.aw_held = 1'b0;
            next_cur.w_held = 1'b0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp = uart_rx_pkg::RESP_OKAY;
            if (cur.awaddr == uart_rx_pkg::CONTROL_OFS) begin
                if (cur.wstrb[0]) begin
                    next_cur.irq_en = cur.wdata[uart_rx_pkg::CT_IE];
                    next_cur.ren = cur.wdata[uart_rx_pkg::CT_REN];
                    next_cur.tx9 = cur.wdata[uart_rx_pkg::CT_TX9];
                end
            end else if (cur.awaddr == uart_rx_pkg::FORMAT_OFS) begin
                if (cur.wstrb[0]) begin
                    next_cur.csz = cur.wdata[uart_rx_pkg::FM_CSZ_HI:uart_rx_pkg::FM_CSZ_LO];
                    next_cur.upm = cur.wdata[uart_rx_pkg::FM_UPM_HI:uart_rx_pkg::FM_UPM_LO];
                    next_cur.usbs = cur.wdata[uart_rx_pkg::FM_USBS];
                end
            end else if (cur.awaddr == uart_rx_pkg::BAUD_OFS) begin
                if (cur.wstrb[0]) begin
                    next_cur.baud[7:0] = cur.wdata[7:0];
                end
                if (cur.wstrb[1]) begin
                    next_cur.baud[15:8] = cur.wdata[15:8];
                end
            end else if ((cur.awaddr == uart_rx_pkg::STATUS_OFS) || (cur.awaddr == uart_rx_pkg::DATA_OFS)) begin
                // error flags not writable; transmit data lives elsewhere
                next_cur.bresp = uart_rx_pkg::RESP_OKAY;
            end else begin
                next_cur.bresp = uart_rx_pkg::RESP_SLVERR;
            end
        end

        // Read channel, data captured at acceptance
        if (cur.rvalid && i_s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && !cur.rvalid) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp = uart_rx_pkg::RESP_OKAY;
            next_cur.rdata = '0;
            if (i_s_axi_araddr == uart_rx_pkg::STATUS_OFS) begin
                next_cur.rdata[7:0] = status_view;
            end else if (i_s_axi_araddr == uart_rx_pkg::CONTROL_OFS) begin
                next_cur.rdata[7:0] = control_view;
            end else if (i_s_axi_araddr == uart_rx_pkg::FORMAT_OFS) begin
                next_cur.rdata[uart_rx_pkg::FM_CSZ_HI:uart_rx_pkg::FM_CSZ_LO] = cur.csz;
                next_cur.rdata[uart_rx_pkg::FM_UPM_HI:uart_rx_pkg::FM_UPM_LO] = cur.upm;
                next_cur.rdata[uart_rx_pkg::FM_USBS] = cur.usbs;
            end else if (i_s_axi_araddr == uart_rx_pkg::DATA_OFS) begin
                next_cur.rdata[7:0] = head.data[7:0];
            end else if (i_s_axi_araddr == uart_rx_pkg::BAUD_OFS) begin
                next_cur.rdata[BW-1:0] = cur.baud;
            end else begin
                next_cur.rresp = uart_rx_pkg::RESP_SLVERR;
            end
        end
    end

    // Single registered state
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cur <= '0;
            cur.st <= uart_rx_pkg::RX_IDLE;
            cur.baud <= BAUD_INIT;
            cur.csz <= uart_rx_pkg::CSZ_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // pin taken over while enabled
    assign o_pin_override = cur.ren;
    // level request, cleared by draining or by clearing the enable; no error term
    assign o_rx_irq = cur.irq_en && rxc;
    assign o_s_axi_awready = !cur.aw_held;
    assign o_s_axi_wready = !cur.w_held;
    assign o_s_axi_bvalid = cur.bvalid;
    assign o_s_axi_bresp = cur.bresp;
    assign o_s_axi_arready = !cur.rvalid;
    assign o_s_axi_rvalid = cur.rvalid;
    assign o_s_axi_rdata = cur.rdata;
    assign o_s_axi_rresp = cur.rresp;

    // ==========================================================
    // Checks
    // ==========================================================
    a_disable_flush: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $fell(cur.ren) |=> !rxc) else $error("buffer not flushed on disable");
    a_disable_idle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !cur.ren |=> (cur.st == uart_rx_pkg::RX_IDLE) && !cur.hold_valid)
        else $error("reception not abandoned");
    a_irq_level: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_rx_irq == (cur.irq_en && (u_fifo.cur.cnt != '0))) else $error("irq does not follow occupancy");
    a_err_no_irq: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!rxc || !cur.irq_en) |-> !o_rx_irq) else $error("irq from error flag");
    a_pop_last: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (pop && rxc && !full && !push) ##1 !push |-> !rxc) else $error("data read did not pop");
    a_frame_err: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (cur.ren && cur.st == uart_rx_pkg::RX_STOP && cur.tick == '0) |=> cur.hold_valid
        && (cur.hold.fe == !$past(i_serial_receive_pin))) else $error("frame error does not match stop bit");
    a_pe_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !cur.upm[1] |-> !status_view[uart_rx_pkg::ST_PE]) else $error("parity flag while off");
    a_overrun_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        drop |=> cur.dor_pend && !cur.hold_valid) else $error("overrun not noted");
    a_overrun_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (push && !drop) |=> !cur.dor_pend) else $error("overrun not cleared on transfer");

endmodule : uart_rx_buffer

// ---- testbench/serial_tx_model.sv ----
/*
 * Far-end serial transmitter: shifts one prepared frame, LSB first.
 * Assumes the bench pulses i_go for one cycle while o_busy is low.
 */
`timescale 1ns/1ps
module serial_tx_model #(
    parameter int BIT_CYC = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic [11:0] i_frame,
    input wire logic [3:0] i_len,
    output logic o_line,
    output logic o_busy
);
    // ==========================================================
    // Frame shifter
    // ==========================================================
    // Line idles high between frames, as a released line would
    initial begin
        o_line = 1'b1;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk_sys);
            if (i_go) begin
                o_busy <= 1'b1;
                o_line <= 1'b0;
                repeat (BIT_CYC) @(posedge i_clk_sys);
                for (int i = 0; i < i_len; i++) begin
                    o_line <= i_frame[i];
                    repeat (BIT_CYC) @(posedge i_clk_sys);
                end
                o_line <= 1'b1;
                o_busy <= 1'b0;
            end
        end
    end
endmodule : serial_tx_model

// ---- testbench/tb.sv ----
/*
 * Self-checking bench for the receive buffer block.
 * Assumes a small divisor (4 cycles a bit) and the register map of the package.
 */
`timescale 1ns/1ps
module tb;
    logic clk, rst, awv, wv, bre, arv, rre, go, line, busy, pin, irq, awr, wr_r, bv, arr, rv;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd_d;
    logic [1:0] br, rr;
    logic [11:0] frm;
    logic [3:0] len;
    logic [8:0] d;
    logic [8:0] q [5];
    logic [33:0] exp_q [$];
    int fails, check_count;
    // ==========================================================
    // Clock, partner and design
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    serial_tx_model #(.BIT_CYC(4)) u_tx (.i_clk_sys(clk), .i_go(go), .i_frame(frm), .i_len(len),
        .o_line(line), .o_busy(busy));
    uart_rx_buffer #(.BAUD_INIT(16'h0003)) u_dut (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_serial_receive_pin(line), .o_pin_override(pin), .o_rx_irq(irq), .i_s_axi_awaddr(awa),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_r), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
        .i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rd_d), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre));
    // ==========================================================
    // Checking and bus tasks
    // ==========================================================
    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic stop_test();
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Read notes its expectation; the monitor below compares it
    task automatic rdr(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        // Ready stays up so a following call never drives it twice in one step
        do @(posedge clk); while (!rv);
    endtask : rdr
    task automatic wrr(input logic [7:0] a, input logic [7:0] v);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        fork
            begin do @(posedge clk); while (!awr); awv <= 1'b0; end
            begin do @(posedge clk); while (!wr_r); wv <= 1'b0; end
        join
        // Ready stays up so a following call never drives it twice in one step
        do @(posedge clk); while (!bv);
    endtask : wrr
    // Frame: data LSB first, optional parity, then first stop bit
    function automatic logic [11:0] mk(input logic [8:0] v, input int nb, input logic [1:0] pm, input logic st);
        logic [11:0] f;
        f = 12'hfff;
        for (int i = 0; i < nb; i++) f[i] = v[i];
        f[nb] = pm[1] ? ((^(v & ((9'h1 << nb) - 9'h1))) ^ pm[0]) : st;
        if (pm[1]) f[nb + 1] = st;
        return f;
    endfunction : mk
    task automatic snd(input logic [11:0] f, input logic [3:0] n);
        frm <= f;
        len <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy);
        repeat (8) @(posedge clk);
    endtask : snd
    // Read response monitor, oldest note first
    always @(posedge clk) begin
        if (rv && rre) chk("read", {rr, rd_d}, exp_q.pop_front());
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {rst, awv, wv, bre, arv, rre, go, awa, ara, wd, frm, len} = {1'b1, 70'h0};
        fails = 0;
        check_count = 0;
        void'($urandom(32'hf36d4c9f));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdr(8'h00, 34'h0);
        rdr(8'h08, 34'h3);
        rdr(8'h20, {uart_rx_pkg::RESP_SLVERR, 32'h0});
        wrr(8'h04, 8'h90);
        chk("pin", {33'h0, pin}, 34'h1);
        d = 9'($urandom);
        snd(mk(d, 8, 2'b00, 1'b1), 4'h9);
        chk("irq", {33'h0, irq}, 34'h1);
        rdr(8'h00, 34'h80);
        rdr(8'h0c, {26'h0, d[7:0]});
        chk("irq", {33'h0, irq}, 34'h0);
        // Bad first stop with two stops configured; status write must not clear it
        wrr(8'h08, 8'h0b);
        snd(mk(d, 8, 2'b00, 1'b0), 4'h9);
        wrr(8'h00, 8'h00);
        rdr(8'h00, 34'h90);
        rdr(8'h0c, {26'h0, d[7:0]});
        // Enable dropped mid-frame; the frame must not surface after re-enable
        fork
            snd(mk(d, 8, 2'b00, 1'b1), 4'h9);
            begin
                repeat (12) @(posedge clk);
                wrr(8'h04, 8'h80);
            end
        join
        chk("pin", {33'h0, pin}, 34'h0);
        wrr(8'h04, 8'h90);
        rdr(8'h00, 34'h0);
        // Even then odd parity, good then failing character
        for (int k = 2; k < 4; k++) begin
            wrr(8'h08, {2'b00, 2'(k), 4'h3});
            snd(mk(d, 8, 2'(k), 1'b1), 4'ha);
            rdr(8'h00, 34'h80);
            rdr(8'h0c, {26'h0, d[7:0]});
            snd(mk(d, 8, {1'b1, ~k[0]}, 1'b1), 4'ha);
            rdr(8'h00, 34'h84);
            wrr(8'h08, 8'h03);
            rdr(8'h00, 34'h80);
            rdr(8'h0c, {26'h0, d[7:0]});
        end
        // Four frames, no reads: third is lost, fourth carries the mark
        for (int k = 0; k < 5; k++) q[k] = 9'($urandom);
        for (int k = 0; k < 4; k++) snd(mk(q[k], 8, 2'b00, 1'b1), 4'h9);
        rdr(8'h00, 34'h80);
        rdr(8'h0c, {26'h0, q[0][7:0]});
        rdr(8'h00, 34'h80);
        rdr(8'h0c, {26'h0, q[1][7:0]});
        rdr(8'h00, 34'h88);
        rdr(8'h0c, {26'h0, q[3][7:0]});
        snd(mk(q[4], 8, 2'b00, 1'b1), 4'h9);
        rdr(8'h00, 34'h80);
        // Full buffer flushed by clearing the enable
        snd(mk(q[1], 8, 2'b00, 1'b1), 4'h9);
        wrr(8'h04, 8'h80);
        rdr(8'h00, 34'h0);
        chk("irq", {33'h0, irq}, 34'h0);
        wrr(8'h04, 8'h90);
        // Short and nine-bit characters
        wrr(8'h08, 8'h00);
        snd(mk(d, 5, 2'b00, 1'b1), 4'h6);
        rdr(8'h0c, {29'h0, d[4:0]});
        wrr(8'h08, 8'h07);
        snd(mk(d, 9, 2'b00, 1'b1), 4'ha);
        rdr(8'h04, {26'h0, 8'h90 | {6'h0, d[8], 1'b0}});
        rdr(8'h0c, {26'h0, d[7:0]});
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule : tb
